// ### verilog/pfc_filter_top.sv
// Behaviour
// RQ1 - proximity low threshold from bytes 0x08/0x09
// RQ2 - proximity high threshold from bytes 0x0A/0x0B
// RQ3 - proximity interrupt: out of range plus persistence
// RQ4 - light interrupt compares channel-0 result only
// RQ5 - separate persistence counters for proximity and light
// RQ6 - proximity setting bits 7:4, zero fires always
// RQ7 - proximity settings 1-15 need that many results
// RQ8 - light setting bits 3:0, zero fires always
// RQ9 - light settings 1-3 need 1-3 results
// RQ10 - light settings 4-15 need five times (setting-3)
// RQ11 - host writes zeros to configuration bits 7:3
// RQ12 - gain level scales 1x/8x light gain by 0.16
// RQ13 - host keeps gain level clear above 8x
// RQ14 - long wait makes wait twelve times longer
// RQ15 - drive reduce cuts LED current by nine
// RQ16 - emit pulse-count LED pulses during accumulation
// RQ17 - LED pulses spaced at 62.5 kHz
// RQ18 - wait counted in 2.73 ms steps
// RQ19 - proximity interrupt gated by its mask
// RQ20 - interrupt clear command clears pending interrupts
// RQ21 - in-range result resets the consecutive counter
`timescale 1ns/1ps
`default_nettype none
module pfc_filter_top
  import pfc_pkg::*;
#(
  parameter int WAIT_STEP_CYCLES = WAIT_STEP_CYC,
  parameter int LED_PERIOD       = LED_PERIOD_CYC,
  parameter int LED_HIGH         = LED_HIGH_CYC
)(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        resetn,
  // register port
  input  wire logic        regWrEn,
  input  wire logic        regRdEn,
  input  wire logic [7:0]  regAddr,
  input  wire logic [7:0]  regWrData,
  output logic      [7:0]  regRdData,
  output logic             regRdValid,
  // neighbouring control fields
  input  wire logic        proxIrqMask,
  input  wire logic        lightIrqMask,
  input  wire logic [1:0]  lightGainSelect,
  input  wire logic [7:0]  waitPeriod,
  input  wire logic [15:0] lightLowThresh,
  input  wire logic [15:0] lightHighThresh,
  // interrupt clear special function
  input  wire logic        proxIrqClear,
  input  wire logic        lightIrqClear,
  // conversion results
  input  wire pfc_result_t proxResult,
  input  wire pfc_result_t chan0Result,
  // sequencing
  input  wire logic        waitStart,
  input  wire logic        proxAccumStart,
  // outputs
  output logic             irqN,
  output logic             proxIrqPending,
  output logic             lightIrqPending,
  output logic             waitBusy,
  output logic             proxAccumBusy,
  output logic             ledDriveOutput,
  output pfc_cfg_t         cfgOut,
  output logic             lightGainScaled
);

  // register file state
  logic [7:0] lowLo_reg, lowHi_reg, highLo_reg, highHi_reg;
  logic [7:0] pers_reg, config_reg, pulseCount_reg;
  logic [7:0] lowLo_next, lowHi_next, highLo_next, highHi_next;
  logic [7:0] pers_next, config_next, pulseCount_next;
  logic [7:0] rdData_reg, rdData_next;
  logic       rdValid_reg, rdValid_next;

  // register writes and reads; unmapped offsets read as zero
  always_comb
  begin
    lowLo_next      = lowLo_reg;
    lowHi_next      = lowHi_reg;
    highLo_next     = highLo_reg;
    highHi_next     = highHi_reg;
    pers_next       = pers_reg;
    config_next     = config_reg;
    pulseCount_next = pulseCount_reg;
    rdData_next     = 8'h00;
    rdValid_next    = regRdEn;
    if (regWrEn)
    begin
      case (regAddr)
        PROX_LOW_THRESH_LO_OFS:  lowLo_next = regWrData;       // RQ1
        PROX_LOW_THRESH_HI_OFS:  lowHi_next = regWrData;       // RQ1
        PROX_HIGH_THRESH_LO_OFS: highLo_next = regWrData;      // RQ2
        PROX_HIGH_THRESH_HI_OFS: highHi_next = regWrData;      // RQ2
        INTERRUPT_PERS_OFS:      pers_next = regWrData;
        // bits 7:3 are stored as written; the host keeps them zero
        GAIN_WAIT_DRIVE_OFS:     config_next = regWrData;      // RQ11
        LED_PULSE_COUNT_OFS:     pulseCount_next = regWrData;
        default:                 ;
      endcase
    end
    if (regRdEn)
    begin
      case (regAddr)
        PROX_LOW_THRESH_LO_OFS:  rdData_next = lowLo_reg;
        PROX_LOW_THRESH_HI_OFS:  rdData_next = lowHi_reg;
        PROX_HIGH_THRESH_LO_OFS: rdData_next = highLo_reg;
        PROX_HIGH_THRESH_HI_OFS: rdData_next = highHi_reg;
        INTERRUPT_PERS_OFS:      rdData_next = pers_reg;
        GAIN_WAIT_DRIVE_OFS:     rdData_next = config_reg;
        LED_PULSE_COUNT_OFS:     rdData_next = pulseCount_reg;
        default:                 rdData_next = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      lowLo_reg      <= THRESH_RESET;
      lowHi_reg      <= THRESH_RESET;
      highLo_reg     <= THRESH_RESET;
      highHi_reg     <= THRESH_RESET;
      pers_reg       <= PERS_RESET;
      config_reg     <= CONFIG_RESET;
      pulseCount_reg <= PULSE_COUNT_RESET;
      rdData_reg     <= 8'h00;
      rdValid_reg    <= 1'b0;
    end
    else
    begin
      lowLo_reg      <= lowLo_next;
      lowHi_reg      <= lowHi_next;
      highLo_reg     <= highLo_next;
      highHi_reg     <= highHi_next;
      pers_reg       <= pers_next;
      config_reg     <= config_next;
      pulseCount_reg <= pulseCount_next;
      rdData_reg     <= rdData_next;
      rdValid_reg    <= rdValid_next;
    end
  end

  // thresholds, settings and comparisons
  logic [15:0] proxLowThresh, proxHighThresh;
  logic [3:0]  proxPers, lightPers;
  logic [5:0]  proxRequired, lightRequired;
  logic        proxOut, lightOut, proxFire, lightFire;

  assign proxLowThresh  = {lowHi_reg, lowLo_reg};   // RQ1
  assign proxHighThresh = {highHi_reg, highLo_reg}; // RQ2
  assign proxPers  = pers_reg[PROX_PERS_MSB:PROX_PERS_LSB];    // RQ6
  assign lightPers = pers_reg[LIGHT_PERS_MSB:LIGHT_PERS_LSB];  // RQ8
  assign proxRequired = {2'b00, proxPers}; // RQ7
  // light setting above 3 maps to 5*(setting-3): 5,10,...,60
  assign lightRequired = (lightPers <= LIGHT_PERS_LINEAR) ? {2'b00, lightPers} // RQ9
    : 6'((6'(lightPers) - LIGHT_PERS_BASE) * LIGHT_PERS_STEP);               // RQ10
  assign proxOut  = (proxResult.value < proxLowThresh)
                 || (proxResult.value > proxHighThresh);                      // RQ3
  assign lightOut = (chan0Result.value < lightLowThresh)
                 || (chan0Result.value > lightHighThresh);                    // RQ4

  // one filter per function, each with its own counter
  pfc_persist #(.CNT_W(6)) proxFilter ( // RQ5
    .clk        (clk),
    .resetn     (resetn),
    .sample     (proxResult.done),
    .outOfRange (proxOut),
    .required   (proxRequired),
    .fire       (proxFire)
  );

  pfc_persist #(.CNT_W(6)) lightFilter ( // RQ5
    .clk        (clk),
    .resetn     (resetn),
    .sample     (chan0Result.done),
    .outOfRange (lightOut),
    .required   (lightRequired),
    .fire       (lightFire)
  );

  // pending flags; a new request beats a clear in the same cycle
  logic proxPend_reg, proxPend_next, lightPend_reg, lightPend_next, irqN_reg, irqN_next;

  always_comb
  begin
    proxPend_next  = proxPend_reg;
    lightPend_next = lightPend_reg;
    if (proxIrqClear)
      proxPend_next = 1'b0;  // RQ20
    if (lightIrqClear)
      lightPend_next = 1'b0; // RQ20
    if (proxFire && proxIrqMask)
      proxPend_next = 1'b1;  // RQ19
    if (lightFire && lightIrqMask)
      lightPend_next = 1'b1;
    irqN_next = !(proxPend_next || lightPend_next);
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      proxPend_reg  <= 1'b0;
      lightPend_reg <= 1'b0;
      irqN_reg      <= 1'b1;
    end
    else
    begin
      proxPend_reg  <= proxPend_next;
      lightPend_reg <= lightPend_next;
      irqN_reg      <= irqN_next;
    end
  end

  // wait timer: 2.73 ms steps, each stretched twelve times under long wait
  localparam int STEP_W = $clog2(WAIT_STEP_CYCLES * LONG_WAIT_MULT + 1);
  logic [STEP_W-1:0] stepCyc_reg, stepCyc_next, stepLen;
  logic [8:0]        steps_reg, steps_next;
  logic              waitBusy_reg, waitBusy_next;

  assign stepLen = config_reg[LONG_WAIT_BIT]
    ? STEP_W'(WAIT_STEP_CYCLES * LONG_WAIT_MULT)  // RQ14
    : STEP_W'(WAIT_STEP_CYCLES);                  // RQ18

  always_comb
  begin
    stepCyc_next  = stepCyc_reg;
    steps_next    = steps_reg;
    waitBusy_next = waitBusy_reg;
    if (!waitBusy_reg)
    begin
      if (waitStart)
      begin
        // period is two's complement: 0xFF is one step, 0x00 is 256
        steps_next    = 9'h100 - {1'b0, waitPeriod}; // RQ18
        stepCyc_next  = '0;
        waitBusy_next = 1'b1;
      end
    end
    else if (stepCyc_reg == stepLen - 1'b1)
    begin
      stepCyc_next = '0;
      steps_next   = steps_reg - 1'b1;
      if (steps_reg == 9'h001)
        waitBusy_next = 1'b0;
    end
    else
      stepCyc_next = stepCyc_reg + 1'b1;
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      stepCyc_reg  <= '0;
      steps_reg    <= 9'h000;
      waitBusy_reg <= 1'b0;
    end
    else
    begin
      stepCyc_reg  <= stepCyc_next;
      steps_reg    <= steps_next;
      waitBusy_reg <= waitBusy_next;
    end
  end

  // LED pulse train during proximity accumulation
  typedef enum logic [0:0] {LED_IDLE, LED_RUN} pfc_led_state_t;
  pfc_led_state_t    ledState_reg, ledState_next;
  localparam int PH_W = $clog2(LED_PERIOD + 1);
  logic [PH_W-1:0]   phase_reg, phase_next;
  logic [7:0]        left_reg, left_next;
  logic              led_reg, led_next;
  logic              accBusy_reg, accBusy_next;

  always_comb
  begin
    ledState_next = ledState_reg;
    phase_next    = phase_reg;
    left_next     = left_reg;
    led_next      = 1'b0;
    case (ledState_reg)
      LED_IDLE:
      begin
        if (proxAccumStart && pulseCount_reg != 8'h00)
        begin
          ledState_next = LED_RUN;
          left_next     = pulseCount_reg; // RQ16
          phase_next    = '0;
          led_next      = 1'b1;
        end
      end
      LED_RUN:
      begin
        if (phase_reg == PH_W'(LED_PERIOD - 1))
        begin
          phase_next = '0;
          left_next  = left_reg - 1'b1;
          if (left_reg == 8'h01)
            ledState_next = LED_IDLE;
          else
            led_next = 1'b1;
        end
        else
        begin
          phase_next = phase_reg + 1'b1;
          led_next   = (phase_next < PH_W'(LED_HIGH)); // RQ17
        end
      end
      default:
        ledState_next = LED_IDLE;
    endcase
    // registered so the busy output leaves straight from a flop
    accBusy_next = (ledState_next == LED_RUN);
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      ledState_reg <= LED_IDLE;
      phase_reg    <= '0;
      left_reg     <= 8'h00;
      led_reg      <= 1'b0;
      accBusy_reg  <= 1'b0;
    end
    else
    begin
      ledState_reg <= ledState_next;
      phase_reg    <= phase_next;
      left_reg     <= left_next;
      led_reg      <= led_next;
      accBusy_reg  <= accBusy_next;
    end
  end

  // cycles since the LED last rose; kept apart from phase so the spacing check is independent
  logic [PH_W-1:0] sinceRise_reg, sinceRise_next;

  always_comb
  begin
    sinceRise_next = sinceRise_reg;
    if (led_next && !led_reg)
      sinceRise_next = '0;
    else if (sinceRise_reg != '1)
      sinceRise_next = sinceRise_reg + 1'b1;
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      sinceRise_reg <= '1;
    else
      sinceRise_reg <= sinceRise_next;
  end

  // analog-facing configuration; the analog side applies 0.16 and 1/9
  pfc_cfg_t cfg_reg;
  logic     scaled_reg;
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      cfg_reg    <= '0;
      scaled_reg <= 1'b0;
    end
    else
    begin
      cfg_reg.lightGainLevel <= config_reg[GAIN_LEVEL_BIT];   // RQ12
      cfg_reg.longWait       <= config_reg[LONG_WAIT_BIT];    // RQ14
      cfg_reg.ledDriveReduce <= config_reg[DRIVE_REDUCE_BIT]; // RQ15
      // only 1x and 8x are scaled; higher gains ignore the bit
      scaled_reg <= config_reg[GAIN_LEVEL_BIT] && (lightGainSelect <= GAIN_SEL_8X); // RQ12
    end
  end

  assign regRdData       = rdData_reg;
  assign regRdValid      = rdValid_reg;
  assign irqN            = irqN_reg;
  assign proxIrqPending  = proxPend_reg;
  assign lightIrqPending = lightPend_reg;
  assign waitBusy        = waitBusy_reg;
  assign proxAccumBusy   = accBusy_reg;
  assign ledDriveOutput  = led_reg;
  assign cfgOut          = cfg_reg;
  assign lightGainScaled = scaled_reg;

  sequence proxEvent_s;
    proxResult.done && proxIrqMask && (proxPers == 4'h0);
  endsequence
  sequence proxFlagged_s;
    ##1 proxFire ##1 proxPend_reg && !irqN;
  endsequence

  chk_prox_every_cycle : assert property (@(posedge clk) disable iff (!resetn) // RQ6
    proxEvent_s |-> proxFlagged_s)
    else $error("zero proximity setting did not raise interrupt");
  chk_prox_mask_gate : assert property (@(posedge clk) disable iff (!resetn) // RQ19
    $rose(proxPend_reg) |-> $past(proxFire && proxIrqMask))
    else $error("proximity flag set without masked request");
  chk_prox_in_range : assert property (@(posedge clk) disable iff (!resetn) // RQ3
    proxResult.done && !proxOut && proxPers != 4'h0 |=> !proxFire)
    else $error("in-range proximity result fired");
  chk_light_pers_map : assert property (@(posedge clk) disable iff (!resetn) // RQ10
    lightPers == 4'hF |-> lightRequired == 6'h3C)
    else $error("light setting 15 not mapped to 60");
  chk_light_low_map : assert property (@(posedge clk) disable iff (!resetn) // RQ9
    lightPers == 4'h3 |-> lightRequired == 6'h03)
    else $error("light setting 3 not mapped to 3");
  chk_irq_clear : assert property (@(posedge clk) disable iff (!resetn) // RQ20
    proxIrqClear && lightIrqClear && !proxFire && !lightFire |=> irqN)
    else $error("clear did not release interrupt");
  chk_thresh_write : assert property (@(posedge clk) disable iff (!resetn) // RQ2
    regWrEn && regAddr == PROX_HIGH_THRESH_HI_OFS |=> proxHighThresh[15:8] == $past(regWrData))
    else $error("high threshold upper byte not written");
  // a repeat pulse inside a train must start one full period after the last one
  chk_led_period : assert property (@(posedge clk) disable iff (!resetn) // RQ17
    ledState_reg == LED_RUN && led_next && !led_reg |-> sinceRise_reg == PH_W'(LED_PERIOD - 1))
    else $error("LED pulse spacing wrong");
  chk_wait_start : assert property (@(posedge clk) disable iff (!resetn) // RQ18
    waitStart && !waitBusy_reg |=> waitBusy_reg ##1 waitBusy_reg)
    else $error("wait timer did not start");

endmodule : pfc_filter_top
`default_nettype wire

// ### pkg/pfc_pkg.sv
package pfc_pkg;

  // register offsets
  localparam logic [7:0] PROX_LOW_THRESH_LO_OFS  = 8'h08;
  localparam logic [7:0] PROX_LOW_THRESH_HI_OFS  = 8'h09;
  localparam logic [7:0] PROX_HIGH_THRESH_LO_OFS = 8'h0A;
  localparam logic [7:0] PROX_HIGH_THRESH_HI_OFS = 8'h0B;
  localparam logic [7:0] INTERRUPT_PERS_OFS      = 8'h0C;
  localparam logic [7:0] GAIN_WAIT_DRIVE_OFS     = 8'h0D;
  localparam logic [7:0] LED_PULSE_COUNT_OFS     = 8'h0E;

  // values after reset
  localparam logic [7:0] THRESH_RESET      = 8'h00;
  localparam logic [7:0] PERS_RESET        = 8'h00;
  localparam logic [7:0] CONFIG_RESET      = 8'h00;
  localparam logic [7:0] PULSE_COUNT_RESET = 8'h00;

  // field positions
  localparam int PROX_PERS_MSB   = 7;
  localparam int PROX_PERS_LSB   = 4;
  localparam int LIGHT_PERS_MSB  = 3;
  localparam int LIGHT_PERS_LSB  = 0;
  localparam int GAIN_LEVEL_BIT  = 2;
  localparam int LONG_WAIT_BIT   = 1;
  localparam int DRIVE_REDUCE_BIT = 0;

  // light persistence map: settings above LIGHT_PERS_LINEAR count in fives
  localparam logic [3:0] LIGHT_PERS_LINEAR = 4'h3;
  localparam logic [5:0] LIGHT_PERS_STEP   = 6'h05;
  localparam logic [5:0] LIGHT_PERS_BASE   = 6'h03;

  // light gain select codes that the gain level scales (1x and 8x)
  localparam logic [1:0] GAIN_SEL_8X = 2'h1;

  // timing
  localparam int CLK_PERIOD_NS   = 25;
  localparam int CLK_HZ          = 40000000;
  localparam int WAIT_STEP_NS    = 2730000;  // 2.73 ms
  localparam int WAIT_STEP_CYC   = WAIT_STEP_NS / CLK_PERIOD_NS;
  localparam int LONG_WAIT_MULT  = 12;
  localparam int LED_RATE_HZ     = 62500;    // 62.5 kHz
  localparam int LED_PERIOD_CYC  = CLK_HZ / LED_RATE_HZ;
  localparam int LED_HIGH_CYC    = LED_PERIOD_CYC / 2;
  localparam int DRIVE_REDUCE_DIV = 9;

  // configuration bits as one group
  typedef struct packed {
    logic lightGainLevel;
    logic longWait;
    logic ledDriveReduce;
  } pfc_cfg_t;

  // one conversion result with its strobe
  typedef struct packed {
    logic        done;
    logic [15:0] value;
  } pfc_result_t;

endpackage : pfc_pkg

// ### verilog/pfc_persist.sv
`timescale 1ns/1ps
`default_nettype none
module pfc_persist
  import pfc_pkg::*;
#(
  parameter int CNT_W = 6
)(
  // clock and reset
  input  wire logic             clk,
  input  wire logic             resetn,
  // one result per strobe
  input  wire logic             sample,
  input  wire logic             outOfRange,
  input  wire logic [CNT_W-1:0] required,
  // one-cycle interrupt request
  output logic                  fire
);

  logic [CNT_W-1:0] runCount_reg;
  logic [CNT_W-1:0] runCount_next;
  logic             fire_reg;
  logic             fire_next;

  // consecutive out-of-range counter; saturates so long runs keep firing
  always_comb
  begin
    runCount_next = runCount_reg;
    fire_next     = 1'b0;
    if (sample)
    begin
      if (!outOfRange)
        runCount_next = '0; // RQ21
      else if (runCount_reg != '1)
        runCount_next = runCount_reg + 1'b1;
      // zero setting fires on every result, in range or not
      fire_next = (required == '0) || (outOfRange && runCount_next >= required); // RQ7
    end
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      runCount_reg <= '0;
      fire_reg     <= 1'b0;
    end
    else
    begin
      runCount_reg <= runCount_next;
      fire_reg     <= fire_next;
    end
  end

  assign fire = fire_reg;

  chk_persist_inrange_clear : assert property (@(posedge clk) disable iff (!resetn) // RQ21
    sample && !outOfRange |=> runCount_reg == '0)
    else $error("run counter not cleared by in-range result");

endmodule : pfc_persist
`default_nettype wire

// ### tb/pfc_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module pfc_host_model
  import pfc_pkg::*;
(
  // clock and reset
  input  wire logic clk,
  input  wire logic resetn,
  // service request from the bench and flags seen
  input  wire logic serviceEn,
  input  wire logic proxIrqPending,
  input  wire logic lightIrqPending,
  // interrupt clear special function
  output logic      proxIrqClear,
  output logic      lightIrqClear
);
  // one clear pulse per raised flag; changed just after the edge so the device samples it clean
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      proxIrqClear  <= 1'b0;
      lightIrqClear <= 1'b0;
    end
    else
    begin
      proxIrqClear  <= serviceEn && proxIrqPending && !proxIrqClear;
      lightIrqClear <= serviceEn && lightIrqPending && !lightIrqClear;
    end
  end
endmodule : pfc_host_model
`default_nettype wire

// ### tb/pfc_filter_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module pfc_filter_tb_top
  import pfc_pkg::*;
;
  logic        clk, resetn, wrEn, rdEn, proxMask, lightMask, waitStart, accStart, serviceEn;
  logic [7:0]  addr, wdata, waitPer, rdData;
  logic [1:0]  gainSel;
  logic [15:0] lightLo, lightHi;
  pfc_result_t proxRes, chan0Res;
  logic        rdValid, proxClr, lightClr, irqN, proxPend, lightPend;
  logic        waitBusy, accBusy, led, gainScaled;
  pfc_cfg_t    cfg;
  int          failCount, comparisons;

  // wait step shrunk to 4 cycles; led timing kept at package values
  pfc_filter_top #(.WAIT_STEP_CYCLES(4)) dut_u (.clk(clk), .resetn(resetn),
    .regWrEn(wrEn), .regRdEn(rdEn), .regAddr(addr), .regWrData(wdata), .regRdData(rdData),
    .regRdValid(rdValid), .proxIrqMask(proxMask), .lightIrqMask(lightMask),
    .lightGainSelect(gainSel), .waitPeriod(waitPer), .lightLowThresh(lightLo),
    .lightHighThresh(lightHi), .proxIrqClear(proxClr), .lightIrqClear(lightClr),
    .proxResult(proxRes), .chan0Result(chan0Res), .waitStart(waitStart),
    .proxAccumStart(accStart), .irqN(irqN), .proxIrqPending(proxPend),
    .lightIrqPending(lightPend), .waitBusy(waitBusy), .proxAccumBusy(accBusy),
    .ledDriveOutput(led), .cfgOut(cfg), .lightGainScaled(gainScaled));

  // host side that answers pending flags
  pfc_host_model host_u (.clk(clk), .resetn(resetn), .serviceEn(serviceEn),
    .proxIrqPending(proxPend), .lightIrqPending(lightPend),
    .proxIrqClear(proxClr), .lightIrqClear(lightClr));

  // 40 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    comparisons++;
    if (got !== exp)
    begin
      failCount++;
      $display("wrong value %s expected %0h seen %0h", what, exp, got);
    end
  endtask : chk

  task automatic wrap_up();
    $display("comparisons %0d mismatches %0d", comparisons, failCount);
    if (failCount == 0 && comparisons > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : wrap_up

  task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk);
    {wrEn, addr, wdata} = {1'b1, a, d};
    @(negedge clk);
    wrEn = 1'b0;
  endtask : reg_wr

  // read, then look at the one-cycle answer
  task automatic reg_chk(input logic [7:0] a, input logic [7:0] exp);
    @(negedge clk);
    {rdEn, addr} = {1'b1, a};
    @(negedge clk);
    rdEn = 1'b0;
    chk("read valid", 1'b1, rdValid);
    chk("read data", exp, rdData);
  endtask : reg_chk

  // one conversion result, then long enough for the pending flag to land
  task automatic send(input logic lt, input logic [15:0] v);
    @(negedge clk);
    if (lt)
      chan0Res = '{1'b1, v};
    else
      proxRes = '{1'b1, v};
    @(negedge clk);
    chan0Res.done = 1'b0;
    proxRes.done = 1'b0;
    repeat (2) @(negedge clk);
  endtask : send

  function automatic logic pend(input logic lt);
    return lt ? lightPend : proxPend;
  endfunction : pend

  task automatic clear_irq();
    serviceEn = 1'b1;
    repeat (3) @(negedge clk);
    serviceEn = 1'b0;
    @(negedge clk);
  endtask : clear_irq

  // run of req-1 misses, in-range break, req-1 misses, then the one that fires
  task automatic pers(input logic lt, input logic [3:0] s, input int req);
    reg_wr(INTERRUPT_PERS_OFS, lt ? {4'h0, s} : {s, 4'h0});
    send(lt, 16'h0100); // equal to high threshold counts as in range
    clear_irq();
    repeat (req - 1) send(lt, 16'h0200);
    chk("pending early", 1'b0, pend(lt));
    send(lt, 16'h0050);
    repeat (req - 1) send(lt, 16'h0005);
    chk("pending after break", 1'b0, pend(lt));
    send(lt, 16'h0005);
    chk("pending at count", 1'b1, pend(lt));
    chk("irq line", 1'b0, irqN);
    chk("other flag", 1'b0, pend(!lt));
    clear_irq();
    chk("pending cleared", 1'b0, pend(lt));
    chk("irq released", 1'b1, irqN);
    $display("test persistence light=%0d setting=%0d done", lt, s);
  endtask : pers

  task automatic wt(input logic [7:0] per, input logic lng, input int exp);
    int n;
    reg_wr(GAIN_WAIT_DRIVE_OFS, {6'h00, lng, 1'b0});
    waitPer = per;
    @(negedge clk);
    waitStart = 1'b1;
    @(negedge clk);
    waitStart = 1'b0;
    n = 0;
    while (waitBusy === 1'b1 && n < 20000)
    begin
      n++;
      @(negedge clk);
    end
    chk("wait length", exp[15:0], n[15:0]);
  endtask : wt

  // watchdog sized well above the expected run of about 3.3k cycles
  initial
  begin
    repeat (20000) @(posedge clk);
    failCount++;
    $display("watchdog expired");
    wrap_up();
  end

  // main sequence
  initial
  begin
    int a, n, hi, r0, r1;
    {wrEn, rdEn, addr, wdata, waitStart, accStart, serviceEn} = '0;
    {proxMask, lightMask, gainSel, waitPer} = {1'b1, 1'b1, 2'h0, 8'hFF};
    {lightLo, lightHi, proxRes, chan0Res} = {16'h0010, 16'h0100, 17'h00000, 17'h00000};
    {failCount, comparisons} = '0;
    resetn = 1'b0;
    repeat (10) @(negedge clk);
    resetn = 1'b1;
    chk("irq after reset", 1'b1, irqN);
    for (a = 8; a <= 14; a++)
      reg_chk(a[7:0], 8'h00);
    for (a = 8; a <= 15; a++)
      reg_wr(a[7:0], (a == 13) ? 8'h05 : {4'h5, a[3:0]});
    for (a = 8; a <= 14; a++)
      reg_chk(a[7:0], (a == 13) ? 8'h05 : {4'h5, a[3:0]});
    reg_chk(8'h0F, 8'h00);
    $display("test registers done");
    reg_wr(PROX_LOW_THRESH_LO_OFS, 8'h10);
    reg_wr(PROX_LOW_THRESH_HI_OFS, 8'h00);
    reg_wr(PROX_HIGH_THRESH_LO_OFS, 8'h00);
    reg_wr(PROX_HIGH_THRESH_HI_OFS, 8'h01);
    reg_wr(INTERRUPT_PERS_OFS, 8'h00);
    send(1'b0, 16'h0050);
    chk("every cycle prox", 1'b1, proxPend);
    send(1'b1, 16'h0050);
    chk("every cycle light", 1'b1, lightPend);
    clear_irq();
    $display("test every cycle done");
    pers(1'b0, 4'h1, 1);
    pers(1'b0, 4'h3, 3);
    pers(1'b0, 4'hF, 15);
    pers(1'b1, 4'h1, 1);
    pers(1'b1, 4'h3, 3);
    pers(1'b1, 4'h4, 5);
    pers(1'b1, 4'hF, 60);
    proxMask = 1'b0;
    reg_wr(INTERRUPT_PERS_OFS, 8'h10);
    send(1'b0, 16'h0200);
    chk("masked pending", 1'b0, proxPend);
    chk("masked irq", 1'b1, irqN);
    proxMask = 1'b1;
    $display("test mask done");
    reg_wr(GAIN_WAIT_DRIVE_OFS, 8'h07);
    // configuration outputs follow the register one clock later
    @(negedge clk);
    chk("config bits", 3'b111, cfg);
    chk("scaled 1x", 1'b1, gainScaled);
    gainSel = 2'h1;
    repeat (2) @(negedge clk);
    chk("scaled 8x", 1'b1, gainScaled);
    reg_wr(GAIN_WAIT_DRIVE_OFS, 8'h03);
    @(negedge clk);
    chk("unscaled", 1'b0, gainScaled);
    $display("test config done");
    wt(8'hFF, 1'b0, 4);
    wt(8'hFE, 1'b0, 8);
    wt(8'h00, 1'b0, 1024);
    wt(8'hFF, 1'b1, 48);
    $display("test wait done");
    reg_wr(LED_PULSE_COUNT_OFS, 8'h02);
    @(negedge clk);
    accStart = 1'b1;
    @(negedge clk);
    accStart = 1'b0;
    {n, hi, r0, r1} = '0;
    while (accBusy === 1'b1 && n < 5000)
    begin
      hi += (led === 1'b1);
      if (led === 1'b1 && (n == 0 || r0 == 0 || r1 == 0) && hi == 1)
        r0 = n + 1;
      if (led === 1'b1 && hi == LED_HIGH_CYC + 1)
        r1 = n + 1;
      n++;
      @(negedge clk);
    end
    chk("led high total", 16'(2 * LED_HIGH_CYC), hi[15:0]);
    chk("led period", 16'(LED_PERIOD_CYC), 16'(r1 - r0));
    reg_wr(LED_PULSE_COUNT_OFS, 8'h00);
    accStart = 1'b1;
    @(negedge clk);
    accStart = 1'b0;
    @(negedge clk);
    chk("zero count idle", 1'b0, accBusy);
    $display("test led done");
    wrap_up();
  end
endmodule : pfc_filter_tb_top
`default_nettype wire
